// File: hdl/sdh_pkg.sv
// Shared constants and types for the device handshake port, both ends
package sdh_pkg;
   localparam int CLK_MHZ       = 250;
   localparam int T_SETUP_NS    = 300;
   localparam int T_SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int T_ANEN_US     = 5;
   localparam int T_ANEN_CYC    = T_ANEN_US * CLK_MHZ;
   localparam int T_ACK_US      = 500;
   localparam int T_ACK_CYC     = T_ACK_US * CLK_MHZ;
   localparam int T_SETTLE_US   = 400;
   localparam int T_SETTLE_CYC  = T_SETTLE_US * CLK_MHZ;
   localparam int T_CONV_US     = 460;
   localparam int T_CONV_CYC    = T_CONV_US * CLK_MHZ;
   localparam int TMR_W         = 17;
   localparam int IDX_W         = 8;
   localparam int ARG_W         = 16;
   localparam int ADC_W         = 12;
   localparam int ADDR_W        = 16;
   localparam int STR_W         = 12;
   localparam logic [STR_W-1:0] STRETCH_CYC = 12'h0FFF;
   localparam int IND_N         = 5;
   localparam int IND_LINE      = 0;
   localparam int IND_MSG       = 1;
   localparam int IND_BUSY      = 2;
   localparam int IND_REPLY     = 3;
   localparam int IND_PARITY    = 4;
   localparam logic [IDX_W-1:0] BLOCK_LO_RST = 8'h00;
   localparam logic [15:0]      ZERO_W       = 16'h0000;
   localparam logic [3:0]       ADC_PAD      = 4'h0;
   localparam logic [15:0]      NRC_MAX      = 16'hFFFF;
   localparam int MUX_PER_UNIT  = 8;
   localparam int NUM_EXT_MUX   = 1;

   // Internal function word selected by a message
   typedef enum logic [1:0] {IFN_NONE, IFN_SERIAL, IFN_REVISION, IFN_NORESP} sdh_ifn_t;
   typedef enum logic [2:0] {D_IDLE, D_SETUP, D_WAIT, D_CONV, D_REPLY} sdh_dev_st_t;
   typedef enum logic [1:0] {E_IDLE, E_WORK, E_ACK} sdh_ext_st_t;
endpackage

// File: hdl/sdh_if.sv
// Parallel link between the interface device and the equipment logic
`timescale 1ns/10ps
`default_nettype none
interface sdh_if;
   import sdh_pkg::*;
   logic [IDX_W-1:0] rel_location_lines;
   logic             dir_select;
   logic             device_request;
   logic [ARG_W-1:0] arg_dev_out;
   logic             arg_dev_oe;
   logic [ARG_W-1:0] arg_ext_out;
   logic             arg_ext_oe;
   logic             device_acknowledge;
   logic             analog_sel_enable;
   logic             upper_bits_select;
   logic [ARG_W-1:0] argument_lines;

   // Wire level of the shared lines; undriven reads as zero (pull-down)
   assign argument_lines = arg_dev_oe ? arg_dev_out : (arg_ext_oe ? arg_ext_out : '0);

   modport dev (output rel_location_lines, dir_select, device_request, arg_dev_out,
                arg_dev_oe, input argument_lines, device_acknowledge,
                analog_sel_enable, upper_bits_select);
   modport ext (input rel_location_lines, dir_select, device_request, argument_lines,
                output arg_ext_out, arg_ext_oe, device_acknowledge,
                analog_sel_enable, upper_bits_select);
endinterface // sdh_if
`default_nettype wire

// File: hdl/sdh_ext_end.sv
// Equipment-side logic answering the device handshake port
`timescale 1ns/10ps
`default_nettype none
module sdh_ext_end
#(
   parameter int NUM_MUX = sdh_pkg::NUM_EXT_MUX
)
(
   input  wire logic                     clk_i,
   input  wire logic                     rstn_i,
   sdh_if.ext                            lnk,
   output logic                          cmd_valid_o,
   output logic [sdh_pkg::IDX_W-1:0]     cmd_index_o,
   output logic [sdh_pkg::ARG_W-1:0]     cmd_data_o,
   output logic                          mon_req_o,
   output logic [sdh_pkg::IDX_W-1:0]     mon_index_o,
   input  wire logic [sdh_pkg::ARG_W-1:0] mon_data_i,
   input  wire logic                     mon_ready_i,
   input  wire logic                     analog_fitted_i
);
   import sdh_pkg::*;

   localparam logic [IDX_W-1:0] AN_HI  = IDX_W'(NUM_MUX * MUX_PER_UNIT + 7);
   localparam logic [IDX_W-1:0] SEL_LO = IDX_W'(MUX_PER_UNIT);

   typedef struct packed {
      sdh_ext_st_t      st;
      logic             ack;
      logic             oe;
      logic [ARG_W-1:0] arg;
      logic             anen;
      logic             usel;
      logic             cv;
      logic [IDX_W-1:0] idx;
      logic [ARG_W-1:0] cdat;
      logic             mreq;
   } sdh_ext_s_t;

   sdh_ext_s_t s_q, s_d;

   // Analog range decode, shared by the enable term and the idle-state branch
   function automatic logic in_analog(input logic [IDX_W-1:0] ra);
      in_analog = analog_fitted_i && (ra <= AN_HI);
   endfunction

   // Handshake sequencing and analog feedback terms
   always_comb
   begin
      s_d    = s_q;
      s_d.cv = 1'b0;
      // Product of direction, request and range decode
      s_d.anen = lnk.dir_select && lnk.device_request && in_analog(lnk.rel_location_lines);
      // Upper bits pick the on-board input above the first unit
      s_d.usel = analog_fitted_i && (NUM_MUX > 0) && (lnk.rel_location_lines >= SEL_LO)
                 && (lnk.rel_location_lines <= AN_HI);
      case (s_q.st)
         E_IDLE:
         begin
            s_d.ack = 1'b0;  // Quiet between messages
            s_d.oe  = 1'b0;
            if (lnk.device_request)
            begin
               s_d.idx = lnk.rel_location_lines;
               if (!lnk.dir_select)
               begin
                  // Capture and route the command argument
                  s_d.cdat = lnk.argument_lines;
                  s_d.cv   = 1'b1;
                  s_d.ack  = 1'b1;
                  s_d.st   = E_ACK;
               end
               else if (!in_analog(lnk.rel_location_lines))
               begin
                  s_d.mreq = 1'b1;
                  s_d.st   = E_WORK;
               end
               else
               begin
                  s_d.st = E_ACK;  // Analog: enable answers, never ack
               end
            end
         end
         E_WORK:
         begin
            if (!lnk.device_request)
            begin
               s_d.mreq = 1'b0;  // Request withdrawn on time-out
               s_d.st   = E_IDLE;
            end
            else if (mon_ready_i)
            begin
               // Drive selected data and acknowledge in the same cycle
               s_d.arg  = mon_data_i;
               s_d.oe   = 1'b1;
               s_d.ack  = 1'b1;
               s_d.mreq = 1'b0;
               s_d.st   = E_ACK;
            end
         end
         default:
         begin
            // Ack held only while request stands
            if (!lnk.device_request)
            begin
               s_d.ack = 1'b0;
               s_d.oe  = 1'b0;
               s_d.st  = E_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         s_q      <= '0;
         s_q.st   <= E_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign lnk.device_acknowledge = s_q.ack;
   assign lnk.arg_ext_oe         = s_q.oe;
   assign lnk.arg_ext_out        = s_q.arg;
   assign lnk.analog_sel_enable  = s_q.anen;
   assign lnk.upper_bits_select  = s_q.usel;
   assign cmd_valid_o            = s_q.cv;
   assign cmd_index_o            = s_q.idx;
   assign cmd_data_o             = s_q.cdat;
   assign mon_req_o              = s_q.mreq;
   assign mon_index_o            = s_q.idx;
endmodule // sdh_ext_end
`default_nettype wire

// File: hdl/sdh_dev_end.sv
// Interface device end: message to parallel handshake, analog path, indicators
`timescale 1ns/10ps
`default_nettype none
// Function
// - Drive index as address minus block start
// - Monitor sets direction high; control drives arguments
// - Raise request only after lines settle
// - Equipment captures, drives data, then acknowledges
// - Latch monitor data on ack, then drop request
// - Equipment raises analog enable within 5 us
// - Control hold until ack or 500 us
// - Missed monitor returns zero data, bad parity
// - Settle 400 us, conversion done by 460 us
// - Equipment never acknowledges without request
// - Index and direction give 256+256 locations
// - Block limits, serial and revision from constants
// - Five stretched activity indicator outputs
// - Idle: index kept, lines released, controls low
// - Outputs may change before request rises
// - Analog option reserves lowest indices
// - Analog result twelve bits, left justified
// - External multiplexers attach upward from input one
// - Upper select picks index bits 3-5
// - Analog enable is direction, request, decode
// - Select and decode ranges per multiplexer count
// - Table ranges are octal, active high
// - Control time-outs count; count clears when read
module sdh_dev_end
#(
   parameter int                          ACK_CYC       = sdh_pkg::T_ACK_CYC,
   parameter int                          SETTLE_CYC    = sdh_pkg::T_SETTLE_CYC,
   parameter int                          CONV_CYC      = sdh_pkg::T_CONV_CYC,
   parameter logic [sdh_pkg::ADDR_W-1:0]  BLOCK_LO      = 16'h0100,
   parameter logic [sdh_pkg::ADDR_W-1:0]  BLOCK_HI      = 16'h01FF,
   parameter logic [sdh_pkg::ARG_W-1:0]   SERIAL_NUM    = 16'h1234, // Arbitrary value
   parameter logic [sdh_pkg::ARG_W-1:0]   REVISION      = 16'h0001, // Arbitrary value
   parameter bit                          ANALOG_FITTED = 1'b1
)
(
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   sdh_if.dev                              lnk,
   input  wire logic                       msg_valid_i,
   input  wire logic [sdh_pkg::ADDR_W-1:0] msg_addr_i,
   input  wire logic                       msg_is_mon_i,
   input  wire sdh_pkg::sdh_ifn_t          msg_ifn_i,
   input  wire logic [sdh_pkg::ARG_W-1:0]  msg_arg_i,
   input  wire logic                       line_transition_i,
   input  wire logic                       msg_detect_i,
   input  wire logic                       reply_tx_i,
   input  wire logic                       parity_err_i,
   input  wire logic [sdh_pkg::ADC_W-1:0]  adc_data_i,
   output logic [2:0]                      mux_sel_o,
   output logic                            adc_sample_o,
   output logic                            rsp_valid_o,
   output logic [sdh_pkg::ARG_W-1:0]       rsp_data_o,
   output logic                            rsp_bad_parity_o,
   output logic                            rsp_noresp_o,
   output logic [sdh_pkg::IND_N-1:0]       ind_o
);
   import sdh_pkg::*;

   localparam logic [TMR_W-1:0] SETUP_T  = TMR_W'(T_SETUP_CYC - 1);
   localparam logic [TMR_W-1:0] ANEN_T   = TMR_W'(T_ANEN_CYC);
   localparam logic [TMR_W-1:0] ACK_T    = TMR_W'(ACK_CYC - 1);
   localparam logic [TMR_W-1:0] SETTLE_T = TMR_W'(SETTLE_CYC - 1);
   localparam logic [TMR_W-1:0] CONV_T   = TMR_W'(CONV_CYC - 1);

   typedef struct packed {
      sdh_dev_st_t            st;
      logic [IDX_W-1:0]       ra;
      logic                   dir;
      logic                   req;
      logic                   oe;
      logic [ARG_W-1:0]       arg;
      logic [TMR_W-1:0]       tmr;
      logic [ARG_W-1:0]       mon;
      logic                   rv;
      logic                   bad;
      logic                   nores;
      logic                   pbad;    // Time-out outcome kept until the answer
      logic                   pnores;
      logic [15:0]            nrc;
      logic [2:0]             mux;
      logic                   smp;
      logic [IND_N-1:0]       ind;
      logic [IND_N*STR_W-1:0] icnt;
   } sdh_dev_s_t;

   sdh_dev_s_t s_q, s_d;

   logic [IND_N-1:0] ev;
   logic             in_block;
   logic [ADDR_W-1:0] rel_full;

   // Block window check; limits are build-time constants
   assign in_block = (msg_addr_i >= BLOCK_LO) && (msg_addr_i <= BLOCK_HI);
   assign rel_full = msg_addr_i - BLOCK_LO;

   // Activity events feeding the stretchers
   assign ev[IND_LINE]   = line_transition_i;
   assign ev[IND_MSG]    = msg_detect_i;
   assign ev[IND_BUSY]   = msg_valid_i && in_block;
   assign ev[IND_REPLY]  = reply_tx_i;
   assign ev[IND_PARITY] = parity_err_i;

   // Sequencer, timers, no-response count and indicator stretch
   always_comb
   begin
      s_d       = s_q;
      s_d.rv    = 1'b0;
      s_d.bad   = 1'b0;
      s_d.nores = 1'b0;
      s_d.smp   = 1'b0;
      // On-board selector from low or high index bits
      s_d.mux = lnk.upper_bits_select ? s_q.ra[5:3] : s_q.ra[2:0];
      // Each event reloads its stretch counter
      for (int i = 0; i < IND_N; i++)
      begin
         if (ev[i])
         begin
            s_d.icnt[i*STR_W +: STR_W] = STRETCH_CYC;
         end
         else if (s_q.icnt[i*STR_W +: STR_W] != '0)
         begin
            s_d.icnt[i*STR_W +: STR_W] = s_q.icnt[i*STR_W +: STR_W] - 1'b1;
         end
         s_d.ind[i] = ev[i] || (s_q.icnt[i*STR_W +: STR_W] != '0);
      end
      case (s_q.st)
         D_IDLE:
         begin
            if (msg_valid_i && in_block)
            begin
               if (msg_ifn_i != IFN_NONE)
               begin
                  // Internal words answer without the parallel port
                  s_d.st = D_REPLY;
                  if (msg_ifn_i == IFN_SERIAL)
                  begin
                     s_d.mon = SERIAL_NUM;
                  end
                  else if (msg_ifn_i == IFN_REVISION)
                  begin
                     s_d.mon = REVISION;
                  end
                  else
                  begin
                     s_d.mon = s_q.nrc;
                     s_d.nrc = '0;  // Read clears the count
                  end
               end
               else
               begin
                  // New index and direction ahead of request
                  s_d.ra  = rel_full[IDX_W-1:0];
                  s_d.dir = msg_is_mon_i;
                  s_d.arg = msg_arg_i;
                  s_d.oe  = !msg_is_mon_i;
                  s_d.tmr = '0;
                  s_d.st  = D_SETUP;
               end
            end
         end
         D_SETUP:
         begin
            // Lines held stable for the setup time first
            s_d.tmr = s_q.tmr + 1'b1;
            if (s_q.tmr == SETUP_T)
            begin
               s_d.req = 1'b1;
               s_d.tmr = '0;
               s_d.st  = D_WAIT;
            end
         end
         D_WAIT:
         begin
            s_d.tmr = s_q.tmr + 1'b1;
            if (lnk.device_acknowledge)
            begin
               // Latch before request falls
               if (s_q.dir)
               begin
                  s_d.mon = lnk.argument_lines;
               end
               s_d.req = 1'b0;
               s_d.oe  = 1'b0;
               s_d.dir = 1'b0;  // Idle levels
               s_d.st  = D_REPLY;
            end
            else if (ANALOG_FITTED && s_q.dir && lnk.analog_sel_enable
                     && (s_q.tmr <= ANEN_T))
            begin
               s_d.st = D_CONV;  // Analog answer
            end
            else if (s_q.tmr == ACK_T)
            begin
               // Time-out drops request, releases lines
               s_d.req = 1'b0;
               s_d.oe  = 1'b0;
               s_d.dir = 1'b0;
               s_d.st  = D_REPLY;
               if (s_q.dir)
               begin
                  s_d.mon  = ZERO_W;  // Zero data, bad parity
                  s_d.pbad = 1'b1;
               end
               else
               begin
                  s_d.pnores = 1'b1;
                  if (s_q.nrc != NRC_MAX)
                  begin
                     s_d.nrc = s_q.nrc + 1'b1;
                  end
               end
            end
         end
         D_CONV:
         begin
            // Sample after settling, result by conversion end
            s_d.tmr = s_q.tmr + 1'b1;
            s_d.smp = (s_q.tmr == SETTLE_T);
            if (s_q.tmr == CONV_T)
            begin
               s_d.mon = {adc_data_i, ADC_PAD};  // Left justified
               s_d.req = 1'b0;
               s_d.dir = 1'b0;
               s_d.st  = D_REPLY;
            end
         end
         default:
         begin
            // One-cycle answer; time-out flags ride in the same cycle
            s_d.rv     = 1'b1;
            s_d.bad    = s_q.pbad;
            s_d.nores  = s_q.pnores;
            s_d.pbad   = 1'b0;
            s_d.pnores = 1'b0;
            s_d.st     = D_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         s_q    <= '0;
         s_q.st <= D_IDLE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // All outputs come from registers
   assign lnk.rel_location_lines = s_q.ra;
   assign lnk.dir_select         = s_q.dir;
   assign lnk.device_request     = s_q.req;
   assign lnk.arg_dev_oe         = s_q.oe;
   assign lnk.arg_dev_out        = s_q.arg;
   assign mux_sel_o              = s_q.mux;
   assign adc_sample_o           = s_q.smp;
   assign rsp_valid_o            = s_q.rv;
   assign rsp_data_o             = s_q.mon;
   assign rsp_bad_parity_o       = s_q.bad;
   assign rsp_noresp_o           = s_q.nores;
   assign ind_o                  = s_q.ind;
endmodule // sdh_dev_end
`default_nettype wire

// File: testbench/sdh_link_checker.sv
// Wire-level protocol checker for the device handshake port
`timescale 1ns/10ps
`default_nettype none
module sdh_link_checker
#(
   parameter int ACK_CYC = 200,
   parameter int NUM_MUX = 1
)
(
   input wire logic        clk_i,
   input wire logic        rstn_i,
   input wire logic [7:0]  rel_location_lines,
   input wire logic        dir_select,
   input wire logic        device_request,
   input wire logic        arg_dev_oe,
   input wire logic        device_acknowledge,
   input wire logic        analog_sel_enable,
   input wire logic        upper_bits_select
);
   int req_cnt_q;
   int req_cnt_d;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // Counts request cycles; a counter avoids unrolling a 200-deep repetition
   always_comb req_cnt_d = device_request ? req_cnt_q + 1 : 0;
   always_ff @(posedge clk_i) req_cnt_q <= rstn_i ? req_cnt_d : 0;

   sequence s_ack_rise;
      $rose(device_acknowledge) && device_request;
   endsequence
   sequence s_req_fall;
      $fell(device_request);
   endsequence

   ack_with_req_a: assert property (
      $rose(device_acknowledge) |-> device_request) else $error("ack without request");
   req_setup_a: assert property (
      $rose(device_request) |-> $past(rel_location_lines, 64) == rel_location_lines
      && $past(dir_select, 64) == dir_select && $past(arg_dev_oe, 64) == arg_dev_oe)
      else $error("request raised before lines settled");
   hold_lines_a: assert property (
      device_request && $past(device_request) |-> $stable(rel_location_lines)
      && $stable(dir_select)) else $error("lines moved during request");
   ack_drop_req_a: assert property (
      s_ack_rise |=> !device_request) else $error("request kept after ack");
   fall_release_a: assert property (
      s_req_fall |-> !arg_dev_oe && !dir_select) else $error("lines not idle after request");
   ack_follow_a: assert property (
      s_req_fall |-> ##[1:2] !device_acknowledge) else $error("ack held after request");
   req_bound_a: assert property (
      req_cnt_q <= ACK_CYC) else $error("request longer than time-out");
   ctl_drive_a: assert property (
      device_request && !dir_select |-> arg_dev_oe) else $error("control args not driven");
   mon_float_a: assert property (
      dir_select |-> !arg_dev_oe) else $error("device drives lines on monitor");
   anen_cause_a: assert property (
      analog_sel_enable |-> $past(device_request) && $past(dir_select))
      else $error("analog enable without monitor request");
   upper_range_a: assert property (
      upper_bits_select |-> $past(rel_location_lines) >= 8
      && $past(rel_location_lines) <= 8 * NUM_MUX + 7) else $error("upper select out of range");
endmodule // sdh_link_checker
`default_nettype wire

// File: testbench/tb_top.sv
// Testbench joining both port ends through the link interface
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import sdh_pkg::*;
   localparam logic [15:0] SER = 16'h2468; // Arbitrary value
   localparam logic [15:0] REV = 16'h0003; // Arbitrary value
   logic        clk_i, rstn_i, ext_rstn, msg_valid_i, msg_is_mon_i, mon_ready_i;
   logic        analog_fitted_i, adc_sample_o, rsp_valid_o, rsp_bad_parity_o;
   logic        rsp_noresp_o, cmd_valid_o, got, c_seen, as_seen, rb, rn;
   logic [15:0] msg_addr_i, msg_arg_i, mon_data_i, rsp_data_o, cmd_data_o, c_dat, rd;
   logic [11:0] adc_data_i;
   logic [7:0]  cmd_index_o, c_idx;
   logic [4:0]  ind_o, msk;
   logic [3:0]  ev;
   logic [2:0]  mux_sel_o, ms;
   sdh_ifn_t    msg_ifn_i;
   int          err_count, num_checks;
   int          ind_map[4] = '{IND_LINE, IND_MSG, IND_REPLY, IND_PARITY};

   sdh_if lnk();
   sdh_dev_end #(.ACK_CYC(200), .SETTLE_CYC(120), .CONV_CYC(160), .SERIAL_NUM(SER),
      .REVISION(REV)) sdh_dev_end_inst (.clk_i(clk_i), .rstn_i(rstn_i), .lnk(lnk),
      .msg_valid_i(msg_valid_i), .msg_addr_i(msg_addr_i), .msg_is_mon_i(msg_is_mon_i),
      .msg_ifn_i(msg_ifn_i), .msg_arg_i(msg_arg_i), .line_transition_i(ev[0]),
      .msg_detect_i(ev[1]), .reply_tx_i(ev[2]), .parity_err_i(ev[3]),
      .adc_data_i(adc_data_i), .mux_sel_o(mux_sel_o), .adc_sample_o(adc_sample_o),
      .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_bad_parity_o(rsp_bad_parity_o),
      .rsp_noresp_o(rsp_noresp_o), .ind_o(ind_o));
   // Separate reset lets the equipment end go silent for time-out cases
   sdh_ext_end sdh_ext_end_inst (.clk_i(clk_i), .rstn_i(ext_rstn), .lnk(lnk),
      .cmd_valid_o(cmd_valid_o), .cmd_index_o(cmd_index_o), .cmd_data_o(cmd_data_o),
      .mon_req_o(), .mon_index_o(), .mon_data_i(mon_data_i), .mon_ready_i(mon_ready_i),
      .analog_fitted_i(analog_fitted_i));
   sdh_link_checker #(.ACK_CYC(200), .NUM_MUX(NUM_EXT_MUX)) sdh_link_checker_inst (.clk_i(clk_i),
      .rstn_i(rstn_i), .rel_location_lines(lnk.rel_location_lines),
      .dir_select(lnk.dir_select), .device_request(lnk.device_request),
      .arg_dev_oe(lnk.arg_dev_oe), .device_acknowledge(lnk.device_acknowledge),
      .analog_sel_enable(lnk.analog_sel_enable), .upper_bits_select(lnk.upper_bits_select));

   // Free-running 250 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %0t: got %h expected %h", $time, s, e);
      end
   endtask

   // One message, then watch for the answer; lines launch at the falling edge
   task automatic send(input logic [15:0] a, input logic m, input sdh_ifn_t f,
                       input logic [15:0] d, input logic want);
      int n;
      n = 0;
      @(negedge clk_i);
      msg_valid_i = 1'b1; msg_addr_i = a; msg_is_mon_i = m; msg_ifn_i = f; msg_arg_i = d;
      @(negedge clk_i);
      msg_valid_i = 1'b0;
      got = 1'b0; c_seen = 1'b0; as_seen = 1'b0;
      while (!got && n < 1000)
      begin
         if (cmd_valid_o === 1'b1)
         begin
            c_seen = 1'b1; c_idx = cmd_index_o; c_dat = cmd_data_o;
         end
         if (adc_sample_o === 1'b1)
         begin
            as_seen = 1'b1; ms = mux_sel_o;
         end
         if (rsp_valid_o === 1'b1)
         begin
            got = 1'b1; rd = rsp_data_o; rb = rsp_bad_parity_o; rn = rsp_noresp_o;
         end
         else
         begin
            @(negedge clk_i);
            n++;
         end
      end
      if (want && !got)
      begin
         err_count++;
         end_sim;
      end
   endtask

   // Main sequence
   initial
   begin
      rstn_i = 1'b0; ext_rstn = 1'b0; msg_valid_i = 1'b0; msg_is_mon_i = 1'b0;
      msg_addr_i = '0; msg_arg_i = '0; msg_ifn_i = IFN_NONE; ev = '0; adc_data_i = '0;
      mon_data_i = '0; mon_ready_i = 1'b0; analog_fitted_i = 1'b1; msk = '0;
      err_count = 0; num_checks = 0;
      repeat (3) @(negedge clk_i);
      rstn_i = 1'b1; ext_rstn = 1'b1;
      check(ind_o, 5'h00);
      for (int k = 0; k < 4; k++)
      begin
         @(negedge clk_i) ev[k] = 1'b1;
         @(negedge clk_i) ev[k] = 1'b0;
         repeat (2) @(negedge clk_i);
         msk[ind_map[k]] = 1'b1;
         check(ind_o, msk);
      end
      $display("indicator test done");
      send(16'h0105, 1'b0, IFN_NONE, 16'hA5C3, 1'b1);
      check(c_idx, 8'h05);
      check({c_seen, c_dat, rn}, {1'b1, 16'hA5C3, 1'b0});
      check({lnk.rel_location_lines, lnk.dir_select, lnk.device_request},
            {8'h05, 1'b0, 1'b0});
      check(lnk.argument_lines, 16'h0000);
      check(ind_o[IND_BUSY], 1'b1);
      $display("control test done");
      mon_ready_i = 1'b1; mon_data_i = 16'h5A96;
      send(16'h0120, 1'b1, IFN_NONE, 16'h0000, 1'b1);
      check({rb, rd}, {1'b0, 16'h5A96});
      mon_ready_i = 1'b0;
      send(16'h0121, 1'b1, IFN_NONE, 16'h0000, 1'b1);
      check({rb, rd}, {1'b1, 16'h0000});
      $display("digital monitor test done");
      adc_data_i = 12'h9AB;
      send(16'h010A, 1'b1, IFN_NONE, 16'h0000, 1'b1);
      check(as_seen, 1'b1);
      check(ms, 3'd1);
      check({rb, rd}, {1'b0, adc_data_i, ADC_PAD});
      // Option absent: the same index must be served as digital data
      analog_fitted_i = 1'b0;
      mon_ready_i = 1'b1;
      mon_data_i = 16'h3C3C;
      send(16'h010A, 1'b1, IFN_NONE, 16'h0000, 1'b1);
      check({as_seen, rb, rd}, {1'b0, 1'b0, 16'h3C3C});
      analog_fitted_i = 1'b1;
      mon_ready_i = 1'b0;
      $display("analog test done");
      ext_rstn = 1'b0;
      send(16'h0107, 1'b0, IFN_NONE, 16'h00FF, 1'b1);
      check({c_seen, rn}, {1'b0, 1'b1});
      ext_rstn = 1'b1;
      send(16'h0100, 1'b1, IFN_NORESP, 16'h0000, 1'b1);
      check(rd, 16'h0001);
      send(16'h0100, 1'b1, IFN_NORESP, 16'h0000, 1'b1);
      check(rd, 16'h0000);
      $display("time-out test done");
      send(16'h01FF, 1'b1, IFN_SERIAL, 16'h0000, 1'b1);
      check(rd, SER);
      send(16'h0100, 1'b1, IFN_REVISION, 16'h0000, 1'b1);
      check(rd, REV);
      send(16'h00FF, 1'b0, IFN_NONE, 16'h1111, 1'b0);
      check({got, c_seen}, 2'b00);
      send(16'h0200, 1'b0, IFN_NONE, 16'h2222, 1'b0);
      check({got, c_seen}, 2'b00);
      $display("block boundary test done");
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
